// >>> core/spe_engine.sv
// serial peripheral port engine: master sequencer, slave shifter, flags
`timescale 1ns/1ps
module spe_engine
  import spe_pkg::*;
(
  // system
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // control and configuration
  input  wire logic              ctrl_wr,
  input  wire spe_ctrl_t         ctrl_wdata,
  output spe_ctrl_t              ctrl_rdata,
  input  wire logic              clock_phase,
  input  wire logic [BITS_W-1:0] bits_per_transfer,
  input  wire logic [RATE_W-1:0] clock_rate,
  input  wire logic              irq_enable,
  // data port
  input  wire logic              data_wr,
  input  wire logic [DATA_W-1:0] data_wdata,
  input  wire logic              data_rd,
  output logic      [DATA_W-1:0] data_rdata,
  // status
  input  wire spe_flags_t        flag_clr,
  output spe_flags_t             flags,
  output logic                   busy,
  output logic                   irq,
  // serial pins
  input  wire logic              link_sck,
  output logic                   sck_o,
  output logic                   sck_oe,
  input  wire logic              mosi_i,
  output logic                   mosi_o,
  output logic                   mosi_oe,
  input  wire logic              miso_i,
  output logic                   miso_o,
  output logic                   miso_oe,
  input  wire logic              slave_select_n
);

  // ****************************************
  // declarations
  // ****************************************
  spe_ctrl_t          ctrl_reg;               // enable bits
  spe_flags_t         flags_reg;              // sticky flags
  spe_mstate_t        mstate_reg;             // master sequencer
  spe_mstate_t        mstate_next;
  logic [RATE_W-1:0]  div_reg;                // half period down counter
  logic               sck_reg;                // master serial clock level
  logic [CNT_W-1:0]   left_reg;               // bits still to sample
  logic               first_reg;              // no bit sampled yet
  logic [DATA_W-1:0]  tx_reg;                 // master transmit shifter
  logic [DATA_W-1:0]  rx_reg;                 // master receive shifter
  logic [DATA_W-1:0]  rbuf_reg;               // receive buffer
  logic               rfull_reg;              // buffer holds unread data
  logic [DATA_W-1:0]  stx_reg;                // slave transmit byte
  logic               irq_reg;
  logic               ssel_prev_reg;          // delayed synced select
  logic [1:0]         pin_sync;               // synced {select, miso}
  logic               ssel_s;
  logic               miso_s;
  logic               master_mode;
  logic               slave_mode;
  logic               tick;                   // divider expiry
  logic               lead;                   // rising serial clock edge
  logic               trail;                  // falling serial clock edge
  logic               samp_edge;
  logic               shift_edge;
  logic               m_end;                  // last trailing edge
  logic               mode_fault;
  logic               s_fin;                  // slave frame closed
  logic               deliver;                // word ready for buffer
  logic [DATA_W-1:0]  word;
  logic               start;
  logic               collide;
  // link domain
  logic               samp_clk;               // slave sampling clock
  logic [CNT_W-1:0]   s_cnt_reg;              // bits sampled this frame
  logic [BITS_W-1:0]  s_out_reg;              // bits shifted out
  logic [DATA_W-1:0]  s_rx_reg;               // slave receive shifter

  // ****************************************
  // pin synchronisers
  // ****************************************
  spe_sync #(
    .WIDTH   (2),
    .RST_VAL (SEL_RST)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({slave_select_n, miso_i}),
    .sync_out (pin_sync)
  );

  assign ssel_s = pin_sync[1];
  assign miso_s = pin_sync[0];

  // ****************************************
  // mode decode
  // ****************************************
  // a disabled block neither drives nor answers
  assign master_mode = ctrl_reg.block_enable & ctrl_reg.master_enable;
  assign slave_mode  = ctrl_reg.block_enable & ~ctrl_reg.master_enable;
  assign mode_fault  = ctrl_reg.master_enable & ~ssel_s;
  assign busy        = (mstate_reg != M_IDLE) | (slave_mode & ~ssel_s);
  // a write during a frame is refused, never queued
  assign collide     = data_wr & busy;
  // only the master may begin shifting
  assign start       = data_wr & ~busy & master_mode & ~mode_fault;

  // ****************************************
  // control register
  // ****************************************
  // the fault outranks a software write in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
    end else if (mode_fault) begin
      ctrl_reg <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_reg <= ctrl_wdata;
    end
  end

  assign ctrl_rdata = ctrl_reg;

  // ****************************************
  // serial clock divider
  // ****************************************
  assign tick  = (mstate_reg == M_RUN) && (div_reg == '0);
  assign lead  = tick & ~sck_reg;
  assign trail = tick & sck_reg;
  // phase chooses which edge samples and which one shifts
  assign samp_edge  = clock_phase ? trail : lead;
  assign shift_edge = clock_phase ? lead : trail;
  assign m_end = trail && (left_reg == (clock_phase ? 4'h1 : 4'h0));

  // half period is clock_rate+1 core cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= RATE_RST;
    end else if (mstate_reg != M_RUN || tick) begin
      div_reg <= clock_rate;
    end else begin
      div_reg <= div_reg - 8'h01;
    end
  end

  // serial clock idles low between transfers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_reg <= 1'b0;
    end else if (mstate_reg != M_RUN) begin
      sck_reg <= 1'b0;
    end else if (tick) begin
      sck_reg <= ~sck_reg;
    end
  end

  // ****************************************
  // master sequencer
  // ****************************************
  // next state; a mode fault abandons any running transfer
  always_comb begin
    mstate_next = mstate_reg;
    unique case (mstate_reg)
      M_IDLE: begin
        if (start) begin
          mstate_next = M_RUN;
        end
      end
      M_RUN: begin
        if (mode_fault) begin
          mstate_next = M_IDLE;
        end else if (m_end) begin
          mstate_next = M_DONE;
        end
      end
      M_DONE: begin
        mstate_next = M_IDLE;
      end
      default: begin
        mstate_next = M_IDLE;                 // unused code
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mstate_reg <= M_IDLE;
    end else begin
      mstate_reg <= mstate_next;
    end
  end

  // bit counter: field value n gives n+1 bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_reg  <= '0;
      first_reg <= 1'b0;
    end else if (start) begin
      left_reg  <= {1'b0, bits_per_transfer} + 4'h1;
      first_reg <= 1'b1;
    end else if (samp_edge) begin
      left_reg  <= left_reg - 4'h1;
      first_reg <= 1'b0;
    end
  end

  // transmit shifter, msb first; the first bit is already on the pin
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= DATA_RST;
    end else if (start) begin
      tx_reg <= data_wdata;
    end else if (shift_edge && !first_reg) begin
      tx_reg <= {tx_reg[DATA_W-2:0], 1'b0};
    end
  end

  // receive shifter; miso arrives two core cycles late through the
  // synchroniser, so very small clock_rate values shorten setup margin
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg <= DATA_RST;
    end else if (samp_edge) begin
      rx_reg <= {rx_reg[DATA_W-2:0], miso_s};
    end
  end

  // ****************************************
  // slave frame end
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ssel_prev_reg <= 1'b1;
    end else begin
      ssel_prev_reg <= ssel_s;
    end
  end

  // rising select closes the frame; the link shifter is quiet by then
  assign s_fin   = slave_mode & ssel_s & ~ssel_prev_reg;
  assign deliver = (mstate_reg == M_DONE) | s_fin;
  assign word    = (mstate_reg == M_DONE) ? rx_reg : s_rx_reg;

  // ****************************************
  // receive buffer
  // ****************************************
  // an unread buffer keeps its byte and the new one is lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rbuf_reg  <= DATA_RST;
      rfull_reg <= 1'b0;
    end else if (deliver && !(rfull_reg && !data_rd)) begin
      rbuf_reg  <= word;
      rfull_reg <= 1'b1;
    end else if (data_rd) begin
      rfull_reg <= 1'b0;
    end
  end

  assign data_rdata = rbuf_reg;

  // ****************************************
  // slave transmit byte
  // ****************************************
  // held still while selected, so the link side may read it directly
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stx_reg <= DATA_RST;
    end else if (data_wr && !busy && slave_mode) begin
      stx_reg <= data_wdata;
    end
  end

  // ****************************************
  // flags
  // ****************************************
  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= FLAGS_RST;
    end else begin
      flags_reg.transfer_done_flag <= deliver |
        (flags_reg.transfer_done_flag & ~flag_clr.transfer_done_flag);
      flags_reg.write_collision_flag <= collide |
        (flags_reg.write_collision_flag & ~flag_clr.write_collision_flag);
      flags_reg.receive_overrun_flag <= (deliver & rfull_reg & ~data_rd) |
        (flags_reg.receive_overrun_flag & ~flag_clr.receive_overrun_flag);
      flags_reg.mode_fault_flag <= mode_fault |
        (flags_reg.mode_fault_flag & ~flag_clr.mode_fault_flag);
    end
  end

  assign flags = flags_reg;

  // interrupt request follows the done flag while enabled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= flags_reg.transfer_done_flag & irq_enable;
    end
  end

  assign irq = irq_reg;

  // ****************************************
  // master pins
  // ****************************************
  assign sck_o   = sck_reg;
  assign sck_oe  = master_mode;
  assign mosi_o  = tx_reg[DATA_W-1];
  assign mosi_oe = master_mode;

  // ****************************************
  // slave link domain
  // ****************************************
  // clock_phase must not change while selected: it retimes the link clock
  assign samp_clk = link_sck ^ clock_phase;

  // sample counter, cleared whenever the select line is high
  always_ff @(posedge samp_clk or posedge slave_select_n) begin
    if (slave_select_n) begin
      s_cnt_reg <= '0;
    end else if (s_cnt_reg != 4'h8) begin
      s_cnt_reg <= s_cnt_reg + 4'h1;
    end
  end

  // slave receive data; read by the core only after the frame closed
  always_ff @(posedge samp_clk) begin
    s_rx_reg <= {s_rx_reg[DATA_W-2:0], mosi_i};
  end

  // output bit index moves on the edge opposite to sampling
  always_ff @(negedge samp_clk or posedge slave_select_n) begin
    if (slave_select_n) begin
      s_out_reg <= '0;
    end else if (s_cnt_reg != 4'h0 && s_out_reg != 3'h7) begin
      s_out_reg <= s_out_reg + 3'h1;
    end
  end

  // unloaded shifter resends the previous byte
  assign miso_o  = stx_reg[3'h7 - s_out_reg];
  assign miso_oe = slave_mode & ~slave_select_n;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  start_runs_a: assert property (start |=> mstate_reg == M_RUN && sck_oe)
    else $error("data write in master mode did not start a transfer");

  // the shifter may only hold or shift; the refused byte must never land
  collide_flag_a: assert property (collide |=> flags.write_collision_flag
    && (tx_reg == $past(tx_reg) || tx_reg == {$past(tx_reg[DATA_W-2:0]), 1'b0}))
    else $error("colliding write not flagged or disturbed the shifter");

  fault_clears_a: assert property (mode_fault |=> !ctrl_rdata.master_enable
    && !ctrl_rdata.block_enable && flags.mode_fault_flag)
    else $error("mode fault did not clear enables");

  done_irq_a: assert property (deliver && irq_enable |=> ##1 irq)
    else $error("interrupt not raised after done");

  overrun_keep_a: assert property (deliver && rfull_reg && !data_rd
    |=> $stable(data_rdata) && flags.receive_overrun_flag)
    else $error("overrun replaced buffer or missed flag");

  buffer_load_a: assert property (deliver && !rfull_reg
    |=> data_rdata == $past(word) && flags.transfer_done_flag)
    else $error("received word not placed in buffer");

  // an idle non master stays idle and off sck and mosi unless software changes mode
  slave_quiet_a: assert property (!master_mode && !ctrl_wr && mstate_reg == M_IDLE
    |=> mstate_reg == M_IDLE && !sck_oe && !mosi_oe)
    else $error("non master started a transfer or drives the pins");

  first_bit_a: assert property (start |=> mosi_o == $past(data_wdata[DATA_W-1]))
    else $error("first bit is not the msb");

  slave_done_a: assert property (s_fin |=> flags.transfer_done_flag)
    else $error("select rising did not mark slave done");

endmodule

// >>> core/spe_pkg.sv
// constants, carrier types and state codes of the serial peripheral port engine
package spe_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int DATA_W = 8;                  // serial word width
  localparam int BITS_W = 3;                  // bits_per_transfer field width
  localparam int RATE_W = 8;                  // serial_clock_rate_reg width
  localparam int CNT_W  = 4;                  // holds up to DATA_W bits left

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [BITS_W-1:0] BITS_RST  = 3'h7;  // eight bits per transfer
  localparam logic              PHASE_RST = 1'h0;  // sample on leading edge
  localparam logic [RATE_W-1:0] RATE_RST  = 8'h00; // fastest divider
  localparam logic [DATA_W-1:0] DATA_RST  = 8'h00; // data registers
  localparam logic [1:0]        SEL_RST   = 2'h3;  // select and miso idle high

  // ****************************************
  // carriers
  // ****************************************
  // serial_control_reg enable bits
  typedef struct packed {
    logic block_enable;
    logic master_enable;
  } spe_ctrl_t;

  // sticky event flags, cleared by software
  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic receive_overrun_flag;
    logic mode_fault_flag;
  } spe_flags_t;

  localparam spe_ctrl_t  CTRL_RST  = '{block_enable: 1'b0, master_enable: 1'b0};
  localparam spe_flags_t FLAGS_RST = '{default: 1'b0};

  // master sequencer states
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_RUN  = 2'b01,
    M_DONE = 2'b10
  } spe_mstate_t;

endpackage

// >>> core/spe_sync.sv
// two flip-flop level synchroniser for pin inputs
`timescale 1ns/1ps
module spe_sync
  import spe_pkg::*;
#(
  parameter int           WIDTH = 2,          // number of levels carried
  parameter logic [WIDTH-1:0] RST_VAL = '0    // value held during reset
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ****************************************
  // synchroniser stages
  // ****************************************
  logic [WIDTH-1:0] meta_reg;                 // first stage, read only below

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// >>> tb/spe_far_end.sv
// far-side model: a serial slave for master runs, a serial master for slave runs
`timescale 1ns/1ps
module spe_far_end (
  // master-side pins of the block
  input  wire logic sck,
  input  wire logic sck_oe,
  input  wire logic cpha,
  input  wire logic mosi,
  output logic      miso,
  // slave-side pins of the block
  input  wire logic dut_miso,
  output logic      link_sck,
  output logic      slv_mosi,
  output logic      sel_n
);
  // ****************************************
  // slave model
  // ****************************************
  logic [7:0] tx_reg;  // byte returned, msb first
  logic [7:0] rx_reg;  // bits taken from mosi
  logic       first;   // phase 1: first rising edge only launches the msb
  // miso shows the inverse while the block does not drive sck, so stale data cannot pass as valid
  assign miso = sck_oe ? tx_reg[7] : ~tx_reg[7];
  // phase 0: sample on rising, shift on falling; phase 1 the reverse
  always @(posedge sck) begin
    if (!cpha) begin
      rx_reg <= {rx_reg[6:0], mosi};
    end else if (!first) begin
      tx_reg <= {tx_reg[6:0], ~tx_reg[0]};
    end
    first <= 1'b0;
  end
  always @(negedge sck) begin
    if (cpha) begin
      rx_reg <= {rx_reg[6:0], mosi};
    end else begin
      tx_reg <= {tx_reg[6:0], ~tx_reg[0]};
    end
  end
  // idle pins; a select pulse clears the block's link counters before use
  initial begin
    tx_reg = 8'h00;
    rx_reg = 8'h00;
    first = 1'b1;
    link_sck = 1'b0;
    slv_mosi = 1'b0;
    sel_n = 1'b0;
    #1 sel_n = 1'b1;
  end
  // preload the byte to send back
  task automatic load(input logic [7:0] b);
    tx_reg = b;
    first = 1'b1;
  endtask
  // drive select alone, used to force a contention
  task automatic hold(input logic v);
    sel_n = v;
  endtask
  // ****************************************
  // master model
  // ****************************************
  // one 8-bit frame; the clock only runs inside it, at 15 ns
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    sel_n = 1'b0;
    #103;
    for (int i = 7; i >= 0; i--) begin
      slv_mosi = tx[i];
      #7.5 link_sck = 1'b1;
      rx[i] = dut_miso;
      #7.5 link_sck = 1'b0;
    end
    #40 sel_n = 1'b1;
    slv_mosi = ~slv_mosi;
  endtask
endmodule

// >>> tb/tb.sv
// self-checking bench of the serial peripheral port engine
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb
  import spe_pkg::*;
();
  // ****************************************
  // signals
  // ****************************************
  int          mismatches = 0;   // failed compares
  int          n_compared = 0;   // all compares
  logic        core_clk = 1'b0;  // 40 MHz core clock
  logic        rst_n, ctrl_wr, data_wr, data_rd, clock_phase, irq_enable;
  spe_ctrl_t   ctrl_wdata, ctrl_rdata;
  spe_flags_t  flag_clr, flags;
  logic [2:0]  bits_per_transfer;
  logic [7:0]  clock_rate, data_wdata, data_rdata;
  logic        busy, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic        far_miso, link_sck, slv_mosi, sel_n;
  // wire levels from the block's enables; the far end drives whenever the block does not
  wire         sck_w  = sck_oe ? sck_o : link_sck;
  wire         mosi_w = mosi_oe ? mosi_o : slv_mosi;
  wire         miso_w = miso_oe ? miso_o : far_miso;
  always #12.5 core_clk = ~core_clk;
  spe_engine u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .ctrl_rdata(ctrl_rdata), .clock_phase(clock_phase), .bits_per_transfer(bits_per_transfer),
    .clock_rate(clock_rate), .irq_enable(irq_enable), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rd(data_rd), .data_rdata(data_rdata),
    .flag_clr(flag_clr), .flags(flags), .busy(busy), .irq(irq), .link_sck(sck_w),
    .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .slave_select_n(sel_n)
  );
  spe_far_end u_far (
    .sck(sck_w), .sck_oe(sck_oe), .cpha(clock_phase), .mosi(mosi_w), .miso(far_miso),
    .dut_miso(miso_w),
    .link_sck(link_sck), .slv_mosi(slv_mosi), .sel_n(sel_n)
  );
  // ****************************************
  // helpers
  // ****************************************
  // n edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic set_ctrl(input logic be, input logic me);
    ctrl_wdata = '{block_enable: be, master_enable: me};
    ctrl_wr = 1'b1;
    cyc(1);
    ctrl_wr = 1'b0;
    cyc(1);
  endtask
  // clear all flags, optionally reading the buffer
  task automatic clr_all(input logic rd);
    flag_clr = '{default: 1'b1};
    data_rd = rd;
    cyc(1);
    flag_clr = '0;
    data_rd = 1'b0;
    cyc(1);
  endtask
  // bounded wait for one flag bit; k returns the cycles spent
  task automatic wait_bit(input int b, output int k);
    k = 0;
    while (flags[b] !== 1'b1) begin
      if (k == 400) begin
        mismatches++;
        $display("Error at %0t: wait timed out", $time);
        conclude();
      end
      cyc(1);
      k++;
    end
  endtask
  // one master run with a write collision inside it
  task automatic xfer(input logic [2:0] n, input logic [7:0] rate, input logic [7:0] tx,
                      input logic [7:0] stx, input logic [7:0] exp_rd);
    int k;
    int base;
    logic [7:0] mask;
    mask = 8'hff >> (7 - n);
    base = 1 + 2 * (n + 1) * (rate + 1);
    bits_per_transfer = n;
    clock_rate = rate;
    u_far.load(stx);
    data_wdata = tx;
    data_wr = 1'b1;
    cyc(1);
    data_wr = 1'b0;
    `CHK(busy, 1'b1)
    cyc(1);
    data_wr = 1'b1;
    data_wdata = ~tx;
    cyc(1);
    data_wr = 1'b0;
    `CHK(flags.write_collision_flag, 1'b1)
    wait_bit(3, k);
    `CHK(k + 3 >= base && k + 3 <= base + 4, 1'b1)
    cyc(1);
    `CHK(irq, irq_enable)
    `CHK(u_far.rx_reg & mask, tx >> (7 - n))
    `CHK(data_rdata & mask, exp_rd >> (7 - n))
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    `CHK(ctrl_rdata, CTRL_RST)
    `CHK(flags, FLAGS_RST)
    `CHK(data_rdata, DATA_RST)
    `CHK({busy, irq, sck_oe, mosi_oe, miso_oe}, 5'h00)
    $display("reset test done");
  endtask
  // every bit count, msb first, with irq on and off
  task automatic t_master();
    set_ctrl(1'b1, 1'b1);
    `CHK({sck_oe, mosi_oe, miso_oe}, 3'h6)
    for (int i = 0; i < 8; i++) begin
      irq_enable = 1'(i);
      xfer(3'(i), 8'h02, 8'(8'hb4 + i), 8'(8'h6d ^ i), 8'(8'h6d ^ i));
      clr_all(1'b1);
    end
    xfer(3'h7, 8'h05, 8'h81, 8'h7e, 8'h7e);
    clr_all(1'b1);
    // other phase: leading edge launches, trailing edge samples
    clock_phase = 1'b1;
    xfer(3'h7, 8'h02, 8'hc3, 8'h96, 8'h96);
    clr_all(1'b1);
    xfer(3'h2, 8'h02, 8'h5e, 8'ha9, 8'ha9);
    clr_all(1'b1);
    clock_phase = 1'b0;
    $display("master test done");
  endtask
  // unread buffer: second byte lost, first kept
  task automatic t_overrun();
    xfer(3'h7, 8'h02, 8'h5a, 8'h11, 8'h11);
    clr_all(1'b0);
    xfer(3'h7, 8'h02, 8'ha5, 8'h22, 8'h11);
    `CHK(flags.receive_overrun_flag, 1'b1)
    clr_all(1'b1);
    $display("overrun test done");
  endtask
  task automatic t_slave();
    int k;
    logic [7:0] rx;
    set_ctrl(1'b1, 1'b0);
    data_wdata = 8'h3c;
    data_wr = 1'b1;
    cyc(1);
    data_wr = 1'b0;
    `CHK({sck_oe, miso_oe, busy}, 3'h0)
    cyc(2);
    u_far.frame(8'ha5, rx);
    cyc(1);
    wait_bit(3, k);
    `CHK(data_rdata, 8'ha5)
    `CHK(rx, 8'h3c)
    clr_all(1'b1);
    $display("slave test done");
  endtask
  // contending master pulls select low
  task automatic t_fault();
    int k;
    set_ctrl(1'b1, 1'b1);
    u_far.hold(1'b0);
    wait_bit(0, k);
    `CHK(ctrl_rdata, CTRL_RST)
    `CHK(sck_oe, 1'b0)
    u_far.hold(1'b1);
    cyc(3);
    clr_all(1'b0);
    $display("fault test done");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {ctrl_wr, data_wr, data_rd, clock_phase, irq_enable} = 5'h00;
    ctrl_wdata = CTRL_RST;
    flag_clr = '0;
    bits_per_transfer = 3'h7;
    clock_rate = 8'h02;
    data_wdata = 8'h00;
    cyc(8);
    rst_n = 1'b1;
    cyc(3);
    t_reset();
    t_master();
    t_overrun();
    t_slave();
    t_fault();
    conclude();
  end
endmodule
